// ===== sar_assertions.sv
// Checker: register port assertions for the stream advance block
`timescale 1ns/1ps
`default_nettype none
module sar_assertions
  import sar_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        cs,
  input wire logic        we,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic rd;
  assign rd = cs && !we;
  // ****
  // Assertions
  // ****
  a_read_answered: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("stray read valid");
  a_rdata_hold: assert property ($changed(rdata) |-> rvalid)
    else $error("read data changed without a read");
  a_ident_value: assert property (rd && addr == IDENT_ADDR |=>
    rdata == {8'h00, REV_DEFAULT, 1'b0, PART_DEFAULT})
    else $error("identity value wrong");
  a_ident_zeros: assert property (rd && addr == IDENT_ADDR |=>
    rdata[15:8] == 8'h00 && !rdata[3])
    else $error("identity reserved bits set");
  a_adv_width: assert property (rd && addr >= LOCAL_ADV_BASE && addr <= BP_ADV_LAST |=>
    rdata[15:2] == 14'h0000)
    else $error("advance upper bits set");
  a_pass_gated: assert property (rd && addr == SELFTEST_ADDR |=>
    (rdata & ~(rdata >> 1) & 16'h0249) == 16'h0000)
    else $error("pass bit without done bit");
  a_st_reserved: assert property (rd && addr == SELFTEST_ADDR |=> rdata[15:13] == 3'h0)
    else $error("self-test reserved bits set");
  a_cs_pulse: assert property (cs |=> !cs)
    else $error("strobe longer than one cycle");
  // ****
  // Coverage
  // ****
  c_st_read: cover property (rd && addr == SELFTEST_ADDR);
  c_done_seen: cover property (rvalid && rdata[10]);
  c_bp_write: cover property (cs && we && addr == BP_ADV_LAST);
endmodule : sar_assertions
`default_nettype wire

// ===== sar_dev.sv
// Device end: output advance registers, memory self-test register, identity
// Function
// (R1) Local shift field sets 0..3 cycles early
// (R2) Zero shift keeps frame-pulse alignment
// (R3) Sixteen backplane advance registers
// (R4) Backplane field bits 1:0, reset zero
// (R5) Software writes zero to bits 15:2
// (R6) Self-test start needs two writes; the device also starts on one write that sets bit 12 and go bits together
// (R7) Bit 12 high enters self-test mode
// (R8) Software clears bit 12 afterwards
// (R9) Test starts on rising start bit
// (R10) Four memories with go/done/pass bits
// (R11) Done flag rises when test finishes
// (R12) Pass bit high means pass; reset zero
// (R13) Identity read-only: revision, part code
// (R14) Identity bits 15:8 and 3 zero
// (R15) Sixteen local advance registers, reset zero
// (R16) New shift applies at frame boundary
// (R17) Control bits read back; status ignores writes
`timescale 1ns/1ps
`default_nettype none
module sar_dev
  import sar_pkg::*;
#(
  parameter int unsigned TEST_CYC  = sar_pkg::TEST_CYC,
  parameter int unsigned FRAME_CYC = sar_pkg::FRAME_CYC,
  parameter logic [3:0]  REV       = sar_pkg::REV_DEFAULT,
  parameter logic [2:0]  PART      = sar_pkg::PART_DEFAULT
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  sar_if.dev                      bus,
  input  wire logic [NMEM-1:0]    mem_fault_i,
  output logic [2*NSTREAM-1:0]    local_out_shift_o,
  output logic [2*NSTREAM-1:0]    bp_out_shift_o,
  output logic                    frame_pulse_out_o,
  output logic                    selftest_enable_o
);
  import sar_pkg::*;

  logic [SHIFT_W-1:0] local_out_shift_reg [NSTREAM];
  logic [SHIFT_W-1:0] bp_out_advance [NSTREAM];
  logic [15:0]        st_ctrl_r;
  logic [NMEM-1:0]    done_w;
  logic [NMEM-1:0]    pass_w;
  logic [15:0]        st_view;
  logic [15:0]        id_view;
  logic [7:0]         frm_cnt_r;
  logic               boundary;
  logic               wr;
  logic               rd;
  logic [15:0]        rdata_nxt;

  assign wr = bus.cs && bus.we;
  assign rd = bus.cs && !bus.we;
  assign boundary = (frm_cnt_r == 8'(FRAME_CYC - 1));

  // ****************************************
  // Advance registers
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < NSTREAM; i++) begin
        local_out_shift_reg[i] <= ADV_RESET[1:0]; // R15
        bp_out_advance[i]      <= ADV_RESET[1:0]; // R4
      end
    end else if (wr) begin
      for (int i = 0; i < NSTREAM; i++) begin
        if (bus.addr == LOCAL_ADV_BASE + 14'(i)) begin
          local_out_shift_reg[i] <= bus.wdata[1:0]; // R15
        end
        if (bus.addr == BP_ADV_BASE + 14'(i)) begin
          bp_out_advance[i] <= bus.wdata[1:0]; // R3 R4
        end
      end
    end
  end

  // ****************************************
  // Frame counter and shift outputs
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      frm_cnt_r         <= 8'h00;
      frame_pulse_out_o <= 1'b0;
    end else begin
      frm_cnt_r         <= boundary ? 8'h00 : frm_cnt_r + 8'h01;
      frame_pulse_out_o <= boundary; // R2
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      local_out_shift_o <= '0;
      bp_out_shift_o    <= '0;
    end else if (boundary) begin // R16
      for (int i = 0; i < NSTREAM; i++) begin
        local_out_shift_o[2*i +: 2] <= local_out_shift_reg[i]; // R1
        bp_out_shift_o[2*i +: 2]    <= bp_out_advance[i];      // R3
      end
    end
  end

  // ****************************************
  // Self-test control
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ctrl_r <= ST_RESET; // R12
    end else if (wr && bus.addr == SELFTEST_ADDR) begin
      st_ctrl_r <= bus.wdata & ST_RW_MASK; // R17
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      selftest_enable_o <= 1'b0;
    end else begin
      selftest_enable_o <= st_ctrl_r[ST_EN_BIT]; // R7
    end
  end

  for (genvar m = 0; m < NMEM; m++) begin : g_mem
    sar_memtest #(.TEST_CYC(TEST_CYC)) u_test ( // R10
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .enable_i (st_ctrl_r[ST_EN_BIT]),       // R7
      .go_i     (st_ctrl_r[3*m+2]),           // R9
      .fault_i  (mem_fault_i[m]),
      .done_o   (done_w[m]),
      .pass_o   (pass_w[m])
    );
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    st_view = st_ctrl_r;
    for (int m = 0; m < NMEM; m++) begin
      st_view[3*m+1] = done_w[m];                // R11
      st_view[3*m]   = done_w[m] & pass_w[m];    // R12
    end
    id_view = 16'h0000;                          // R14
    id_view[REV_LSB +: 4]  = REV;                // R13
    id_view[PART_LSB +: 3] = PART;               // R13
    rdata_nxt = 16'h0000;
    for (int i = 0; i < NSTREAM; i++) begin
      if (bus.addr == LOCAL_ADV_BASE + 14'(i)) begin
        rdata_nxt = {14'h0000, local_out_shift_reg[i]};
      end
      if (bus.addr == BP_ADV_BASE + 14'(i)) begin
        rdata_nxt = {14'h0000, bp_out_advance[i]};
      end
    end
    if (bus.addr == SELFTEST_ADDR) begin
      rdata_nxt = st_view;
    end
    if (bus.addr == IDENT_ADDR) begin
      rdata_nxt = id_view;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus.rdata  <= 16'h0000;
      bus.rvalid <= 1'b0;
    end else begin
      bus.rvalid <= rd;
      if (rd) begin
        bus.rdata <= rdata_nxt;
      end
    end
  end
endmodule : sar_dev
`default_nettype wire

// ===== sar_host.sv
// Host end: register access sequencer for the stream advance block
`timescale 1ns/1ps
`default_nettype none
module sar_host
  import sar_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  sar_if.host              bus,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [15:0] wdata_i,
  output logic             busy_o,
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  import sar_pkg::*;

  sar_hst_t state_r;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= SAR_IDLE;
      bus.cs    <= 1'b0;
      bus.we    <= 1'b0;
      bus.addr  <= 14'h0000;
      bus.wdata <= 16'h0000;
      busy_o    <= 1'b0;
      ack_o     <= 1'b0;
      rdata_o   <= 16'h0000;
    end else begin
      ack_o  <= 1'b0;
      bus.cs <= 1'b0;
      case (state_r)
        SAR_IDLE: begin
          if (req_i) begin
            bus.cs    <= 1'b1;
            bus.we    <= we_i;
            bus.addr  <= addr_i;
            // Reserved bits always sent as zero
            if (addr_i == SELFTEST_ADDR) begin
              bus.wdata <= wdata_i & ST_RW_MASK; // R5 R6 R8
            end else begin
              bus.wdata <= {14'h0000, wdata_i[1:0]}; // R5
            end
            busy_o  <= 1'b1;
            state_r <= we_i ? SAR_WRITE : SAR_READ;
          end
        end
        SAR_WRITE: begin
          ack_o   <= 1'b1;
          busy_o  <= 1'b0;
          state_r <= SAR_IDLE;
        end
        SAR_READ: begin
          if (bus.rvalid) begin
            rdata_o <= bus.rdata; // R11
            ack_o   <= 1'b1;
            busy_o  <= 1'b0;
            state_r <= SAR_IDLE;
          end
        end
        default: begin
          state_r <= SAR_IDLE;
        end
      endcase
    end
  end
endmodule : sar_host
`default_nettype wire

// ===== sar_if.sv
// Interface: parallel register port between host and device
`timescale 1ns/1ps
`default_nettype none
interface sar_if;
  logic        cs;
  logic        we;
  logic [13:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        rvalid;
  modport dev  (input cs, we, addr, wdata, output rdata, rvalid);
  modport host (output cs, we, addr, wdata, input rdata, rvalid);
endinterface : sar_if
`default_nettype wire

// ===== sar_memtest.sv
// Leaf: self-test engine for one internal memory
`timescale 1ns/1ps
`default_nettype none
module sar_memtest #(
  parameter int unsigned TEST_CYC = 200
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic enable_i,
  input  wire logic go_i,
  input  wire logic fault_i,
  output logic      done_o,
  output logic      pass_o
);
  logic        go_q_r;
  logic        busy_r;
  logic        bad_r;
  logic [31:0] cnt_r;

  // ****************************************
  // Edge detect and run
  // ****************************************
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      go_q_r <= 1'b0;
      busy_r <= 1'b0;
      bad_r  <= 1'b0;
      cnt_r  <= 32'h0;
      done_o <= 1'b0;
      pass_o <= 1'b0;
    end else begin
      go_q_r <= go_i;
      if (!enable_i) begin
        busy_r <= 1'b0;
        done_o <= 1'b0;
        pass_o <= 1'b0;
      end else if (go_i && !go_q_r) begin // R9
        busy_r <= 1'b1;
        bad_r  <= 1'b0;
        cnt_r  <= 32'h0;
        done_o <= 1'b0;
        pass_o <= 1'b0;
      end else if (busy_r) begin
        bad_r <= bad_r | fault_i;
        cnt_r <= cnt_r + 32'h1;
        if (cnt_r == TEST_CYC - 1) begin
          busy_r <= 1'b0;
          done_o <= 1'b1;                // R11
          pass_o <= !(bad_r | fault_i);  // R12
        end
      end
    end
  end
endmodule : sar_memtest
`default_nettype wire

// ===== sar_pkg.sv
// Package: register map, field positions and timing constants for the stream advance block
package sar_pkg;

  // ****************************************
  // Bus widths and stream count
  // ****************************************
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NSTREAM = 16;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [13:0] LOCAL_ADV_BASE = 14'h0083;
  localparam logic [13:0] LOCAL_ADV_LAST = 14'h0092;
  localparam logic [13:0] BP_ADV_BASE    = 14'h00a3;
  localparam logic [13:0] BP_ADV_LAST    = 14'h00b2;
  localparam logic [13:0] SELFTEST_ADDR  = 14'h014d;
  localparam logic [13:0] IDENT_ADDR     = 14'h3fff;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned SHIFT_W      = 2;
  localparam logic [15:0] ADV_RESET    = 16'h0000;
  localparam logic [15:0] ST_RESET     = 16'h0000;
  localparam int unsigned ST_EN_BIT    = 12;
  localparam logic [15:0] ST_EN_ONLY   = 16'h1000;
  localparam logic [15:0] ST_RW_MASK   = 16'h1924;
  localparam int unsigned NMEM         = 4;
  // Memory m (0 local conn, 1 bp conn, 2 local data, 3 bp data): go 3m+2, done 3m+1, pass 3m
  localparam int unsigned REV_LSB      = 4;
  localparam int unsigned PART_LSB     = 0;
  // Arbitrary neutral identity values
  localparam logic [3:0]  REV_DEFAULT  = 4'h5;
  localparam logic [2:0]  PART_DEFAULT = 3'h6;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned TEST_US      = 10;
  localparam int unsigned TEST_CYC     = TEST_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FRAME_CYC    = 64;

  typedef enum logic [1:0] {
    SAR_IDLE  = 2'b00,
    SAR_WRITE = 2'b01,
    SAR_READ  = 2'b11
  } sar_hst_t;

endpackage : sar_pkg

// ===== stream_advance_and_mbist_regs_bench.sv
// Testbench: host and device ends joined over the register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module stream_advance_and_mbist_regs_bench;
  import sar_pkg::*;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        req_i = 1'b0;
  logic        we_i = 1'b0;
  logic [13:0] addr_i = 14'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic [3:0]  mem_fault_i = 4'h0;
  logic        busy_o, ack_o, frame_pulse_out_o, selftest_enable_o;
  logic [15:0] rdata_o, rd;
  logic [31:0] local_out_shift_o, bp_out_shift_o;
  logic [1:0]  exp_l [16];
  logic [1:0]  exp_b [16];
  logic [3:0]  flt;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n_poll;
  sar_if sar_if_i ();
  sar_host sar_host_i (.clk_i, .resetn_i, .bus(sar_if_i), .req_i, .we_i, .addr_i, .wdata_i,
    .busy_o, .ack_o, .rdata_o);
  sar_dev #(.TEST_CYC(4), .FRAME_CYC(8)) sar_dev_i (.clk_i, .resetn_i, .bus(sar_if_i),
    .mem_fault_i, .local_out_shift_o, .bp_out_shift_o, .frame_pulse_out_o, .selftest_enable_o);
  sar_assertions sar_assertions_i (.clk_i, .resetn_i, .cs(sar_if_i.cs), .we(sar_if_i.we),
    .addr(sar_if_i.addr), .wdata(sar_if_i.wdata), .rdata(sar_if_i.rdata),
    .rvalid(sar_if_i.rvalid));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ****
  // Tasks and expectations
  // ****
  task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_i <= 1'b1;
    we_i <= w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 10);
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: no ack", $time);
    end
    rd = rdata_o;
  endtask : acc
  task automatic rchk(input logic [13:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    `CHK(rd, e)
  endtask : rchk
  task automatic wait_frame();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (frame_pulse_out_o !== 1'b1 && n < 40);
  endtask : wait_frame
  function automatic logic [15:0] st_exp(input logic [3:0] f);
    st_exp = 16'h1db6;
    for (int m = 0; m < 4; m++) st_exp[3*m] = !f[m];
  endfunction : st_exp
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(93352));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rchk(LOCAL_ADV_BASE + 14'(i), ADV_RESET);
      rchk(BP_ADV_BASE + 14'(i), ADV_RESET);
    end
    rchk(SELFTEST_ADDR, ST_RESET);
    acc(1'b1, IDENT_ADDR, 16'hffff);
    rchk(IDENT_ADDR, {8'h00, REV_DEFAULT, 1'b0, PART_DEFAULT});
    for (int i = 0; i < 16; i++) begin
      exp_l[i] = (i < 4) ? 2'(i) : 2'($urandom);
      exp_b[i] = (i < 4) ? 2'(3 - i) : 2'($urandom);
      acc(1'b1, LOCAL_ADV_BASE + 14'(i), {14'h0000, exp_l[i]});
      acc(1'b1, BP_ADV_BASE + 14'(i), {14'h0000, exp_b[i]});
    end
    wait_frame();
    wait_frame();
    for (int i = 0; i < 16; i++) begin
      rchk(LOCAL_ADV_BASE + 14'(i), {14'h0000, exp_l[i]});
      rchk(BP_ADV_BASE + 14'(i), {14'h0000, exp_b[i]});
      `CHK(local_out_shift_o[2*i+:2], exp_l[i])
      `CHK(bp_out_shift_o[2*i+:2], exp_b[i])
    end
    for (int r = 0; r < 2; r++) begin
      flt = r ? 4'ha : 4'($urandom);
      @(posedge clk_i);
      mem_fault_i <= flt;
      acc(1'b1, SELFTEST_ADDR, ST_EN_ONLY);
      acc(1'b1, SELFTEST_ADDR, 16'h1924);
      `CHK(selftest_enable_o, 1'b1)
      n_poll = 0;
      do begin
        acc(1'b0, SELFTEST_ADDR, 16'h0000);
        n_poll++;
      end while ((rd & 16'h0492) !== 16'h0492 && n_poll < 20);
      `CHK(rd, st_exp(flt))
      @(posedge clk_i);
      mem_fault_i <= ~flt;
      acc(1'b1, SELFTEST_ADDR, 16'h1924);
      repeat (8) @(posedge clk_i);
      rchk(SELFTEST_ADDR, st_exp(flt));
      acc(1'b1, SELFTEST_ADDR, 16'h0000);
      rchk(SELFTEST_ADDR, ST_RESET);
      `CHK(selftest_enable_o, 1'b0)
    end
    acc(1'b1, 14'h0200, 16'h0003);
    rchk(14'h0200, 16'h0000);
    finish_test();
  end
endmodule : stream_advance_and_mbist_regs_bench
`default_nettype wire
